// ==== src/cyc_ctrl_pkg.sv ====
// shared constants and types for the cache cycle-control signalling
// What this block does
// - decode flag low inside interrupt-controller window
// - processor drives lane enables with address
// - before commit controller owns and may abort
// - after commit bus controller finishes the cycle
// - commit pin doubles as drive-strength config
// - burst-final low with final ready acknowledge
// - attribute strobe captures attributes in external latch
// - sram latch open when strobe low
// - back-off driven to break deadlock
// - drivers float bus the clock after back-off
// - processor holds, then reissues aborted cycles
package cyc_ctrl_pkg;
    localparam int ADDR_W = 36;
    localparam int LANES = 8;
    localparam int BEAT_W = 3;
    localparam logic [35:0] LIC_LO = 36'h0FEE00000;
    localparam logic [35:0] LIC_HI = 36'h0FEE003FF;
    localparam logic [7:0] LANES_IDLE = 8'hFF;
    localparam logic [2:0] BEATS_BURST = 3'h3;
    localparam logic [2:0] BEATS_SINGLE = 3'h0;
    localparam logic [7:0] DEADLOCK_LIMIT = 8'h10;
    typedef enum logic [1:0] {own_idle, own_ctrl, own_mbc, own_abort} own_state_type;
endpackage

// ==== src/cyc_ctrl_if.sv ====
// interface joining the controller end and the processor/bus-controller end
`timescale 1ns/10ps
interface cyc_ctrl_if;
    import cyc_ctrl_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic addr_strobe_n;
    logic [LANES-1:0] byte_lane_enables;
    logic page_cache_disable;
    logic page_write_through;
    logic cache_n;
    logic split_cycle_flag;
    logic burst_ack_n;
    logic cache_burst_ack_n;
    logic cycle_commit_in;
    logic cycle_commit_out;
    logic cycle_commit_oe_n;
    logic local_int_ctrl_range_hit_n;
    logic burst_final_n;
    logic attr_latch_strobe_n;
    logic sram_lane_latch_strobe_n;
    logic bus_backoff_n;
    logic bus_floated;
    modport ctrl (input addr, addr_strobe_n, byte_lane_enables, page_cache_disable, page_write_through,
        cache_n, split_cycle_flag, burst_ack_n, cache_burst_ack_n, cycle_commit_in, bus_floated,
        output local_int_ctrl_range_hit_n, burst_final_n, attr_latch_strobe_n,
        sram_lane_latch_strobe_n, bus_backoff_n);
    modport far (output addr, addr_strobe_n, byte_lane_enables, page_cache_disable, page_write_through,
        cache_n, split_cycle_flag, burst_ack_n, cycle_commit_out, cycle_commit_oe_n, bus_floated,
        input local_int_ctrl_range_hit_n, burst_final_n, attr_latch_strobe_n, sram_lane_latch_strobe_n,
        bus_backoff_n, cache_burst_ack_n, cycle_commit_in);
    // the pin is pulled high when nobody drives it; enable is active low
    assign cycle_commit_in = cycle_commit_oe_n ? 1'b1 : cycle_commit_out;
endinterface

// ==== src/sync2.sv ====
// two flip-flop synchroniser for a pin level
`timescale 1ns/10ps
module sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic meta_d;
    logic dout_d;
    // first stage feeds only the second
    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            dout <= RESET_VAL;
        end else if (ce) begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end
endmodule

// ==== src/cache_cycle_ctrl.sv ====
// controller end: decode, strobes, burst-final, commit tracking and back-off
`timescale 1ns/10ps
module cache_cycle_ctrl #(
    parameter logic [7:0] DEADLOCK_LIMIT_P = cyc_ctrl_pkg::DEADLOCK_LIMIT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    cyc_ctrl_if.ctrl bus,
    input wire logic cfg_phase,
    input wire logic burst_req,
    input wire logic snoop_hit,
    input wire logic deadlock,
    output logic drive_strength_cfg,
    output logic cycle_owned_by_mbc,
    output logic cycle_aborted,
    output logic [cyc_ctrl_pkg::LANES-1:0] lanes_latched
);
    import cyc_ctrl_pkg::*;

    logic commit_s;
    logic hit_n_q, hit_n_d;
    logic final_n_q, final_n_d;
    logic ble_n_q, ble_n_d;
    logic sram_lane_latch_strobe_n_q, sram_lane_latch_strobe_n_d;
    logic bus_backoff_n_q, bus_backoff_n_d;
    logic cfg_q, cfg_d;
    logic mbc_q, mbc_d;
    logic abort_q, abort_d;
    logic [LANES-1:0] lanes_q, lanes_d;
    logic [BEAT_W-1:0] beats_q, beats_d;
    logic active_q, active_d;
    logic [7:0] stall_q, stall_d;
    own_state_type st_q, st_d;
    logic ack;

    // the shared pin is a pin input, so it is synchronised before use
    sync2 #(.RESET_VAL(1'b1)) commit_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .din(bus.cycle_commit_in),
        .dout(commit_s)
    );

    assign ack = !bus.burst_ack_n || !bus.cache_burst_ack_n;

    // decode and cycle-start strobes
    always_comb begin
        hit_n_d = !(bus.addr >= LIC_LO && bus.addr <= LIC_HI);
        ble_n_d = bus.addr_strobe_n;
        // lanes arrive with the address; the latch opens the clock after the strobe
        sram_lane_latch_strobe_n_d = bus.addr_strobe_n;
        lanes_d = !sram_lane_latch_strobe_n_q ? bus.byte_lane_enables : lanes_q;
        // config value is only meaningful while the pin is in its config phase
        cfg_d = cfg_phase ? commit_s : cfg_q;
    end

    // burst beat counter: final flag low through the last beat until its acknowledge
    always_comb begin
        beats_d = beats_q;
        active_d = active_q;
        if (!bus.addr_strobe_n) begin
            beats_d = burst_req ? BEATS_BURST : BEATS_SINGLE;
            active_d = 1'b1;
        end else if (ack && active_q) begin
            if (beats_q == BEATS_SINGLE) begin
                active_d = 1'b0;
            end else begin
                beats_d = beats_q - 3'h1;
            end
        end
        // registered early, so it already stands when the last acknowledge arrives
        final_n_d = !(active_d && beats_d == BEATS_SINGLE);
    end

    // ownership of the pending memory bus cycle
    always_comb begin
        st_d = st_q;
        abort_d = 1'b0;
        case (st_q)
            own_idle: begin
                if (!bus.addr_strobe_n && !cfg_phase) st_d = own_ctrl;
            end
            own_ctrl: begin
                if (!commit_s) st_d = own_mbc;
                else if (snoop_hit) st_d = own_abort;
            end
            own_mbc: begin
                // controller is free once committed; the other side completes it
                if (!bus.addr_strobe_n) st_d = own_ctrl;
                else if (commit_s) st_d = own_idle;
            end
            own_abort: begin
                abort_d = 1'b1;
                st_d = own_idle;
            end
            default: st_d = own_idle;
        endcase
        mbc_d = (st_d == own_mbc);
    end

    // back-off: raised on deadlock or a stalled owned cycle
    always_comb begin
        stall_d = (st_q == own_ctrl && stall_q != DEADLOCK_LIMIT_P) ? stall_q + 8'h01 : 8'h00;
        // released only after the far side has floated its drivers
        bus_backoff_n_d = !(deadlock || stall_q == DEADLOCK_LIMIT_P || (!bus_backoff_n_q && !bus.bus_floated));
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hit_n_q <= 1'b1;
            final_n_q <= 1'b1;
            ble_n_q <= 1'b1;
            sram_lane_latch_strobe_n_q <= 1'b1;
            bus_backoff_n_q <= 1'b1;
            cfg_q <= 1'b0;
            mbc_q <= 1'b0;
            abort_q <= 1'b0;
            lanes_q <= LANES_IDLE;
            beats_q <= BEATS_SINGLE;
            active_q <= 1'b0;
            stall_q <= 8'h00;
            st_q <= own_idle;
        end else if (ce) begin
            hit_n_q <= hit_n_d;
            final_n_q <= final_n_d;
            ble_n_q <= ble_n_d;
            sram_lane_latch_strobe_n_q <= sram_lane_latch_strobe_n_d;
            bus_backoff_n_q <= bus_backoff_n_d;
            cfg_q <= cfg_d;
            mbc_q <= mbc_d;
            abort_q <= abort_d;
            lanes_q <= lanes_d;
            beats_q <= beats_d;
            active_q <= active_d;
            stall_q <= stall_d;
            st_q <= st_d;
        end
    end

    assign bus.local_int_ctrl_range_hit_n = hit_n_q;
    assign bus.burst_final_n = final_n_q;
    assign bus.attr_latch_strobe_n = ble_n_q;
    assign bus.sram_lane_latch_strobe_n = sram_lane_latch_strobe_n_q;
    assign bus.bus_backoff_n = bus_backoff_n_q;
    assign drive_strength_cfg = cfg_q;
    assign cycle_owned_by_mbc = mbc_q;
    assign cycle_aborted = abort_q;
    assign lanes_latched = lanes_q;
endmodule

// ==== src/cyc_far_end.sv ====
// far end: processor cycle issue, bus-controller commit, back-off response
`timescale 1ns/10ps
module cyc_far_end (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    cyc_ctrl_if.far bus,
    input wire logic req_valid,
    input wire logic [cyc_ctrl_pkg::ADDR_W-1:0] req_addr,
    input wire logic [cyc_ctrl_pkg::LANES-1:0] req_lanes,
    input wire logic cfg_phase,
    input wire logic cfg_value,
    input wire logic commit_req,
    output logic req_ready,
    output logic reissued
);
    import cyc_ctrl_pkg::*;

    logic bus_backoff_s;
    logic as_n_q, as_n_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [LANES-1:0] lanes_q, lanes_d;
    logic pend_q, pend_d;
    logic float_q, float_d;
    logic rdy_q, rdy_d;
    logic re_q, re_d;
    logic com_q, com_d;
    logic oe_n_q, oe_n_d;

    // same-clock logic; a synchroniser would miss the float-on-next-clock deadline
    assign bus_backoff_s = bus.bus_backoff_n;

    // issue, hold while backed off, then reissue the aborted cycle
    always_comb begin
        addr_d = addr_q;
        lanes_d = lanes_q;
        pend_d = pend_q;
        as_n_d = 1'b1;
        re_d = 1'b0;
        float_d = !bus_backoff_s;
        if (!bus_backoff_s) begin
            as_n_d = 1'b1;
        end else if (float_q && pend_q) begin
            as_n_d = 1'b0;
            re_d = 1'b1;
        end else if (req_valid && !pend_q) begin
            addr_d = req_addr;
            lanes_d = req_lanes;
            pend_d = 1'b1;
            as_n_d = 1'b0;
        end
        if (!com_q && pend_q && bus_backoff_s) pend_d = 1'b0;
        rdy_d = bus_backoff_s && !pend_d;
        // pin is config during config phase, commit handshake otherwise
        oe_n_d = 1'b0;
        com_d = cfg_phase ? cfg_value : !(commit_req && pend_q);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            as_n_q <= 1'b1;
            addr_q <= '0;
            lanes_q <= LANES_IDLE;
            pend_q <= 1'b0;
            float_q <= 1'b0;
            rdy_q <= 1'b0;
            re_q <= 1'b0;
            com_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            as_n_q <= as_n_d;
            addr_q <= addr_d;
            lanes_q <= lanes_d;
            pend_q <= pend_d;
            float_q <= float_d;
            rdy_q <= rdy_d;
            re_q <= re_d;
            com_q <= com_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign bus.addr = addr_q;
    assign bus.addr_strobe_n = as_n_q;
    // lanes stand for the whole pending cycle so the late latch strobe still sees them
    assign bus.byte_lane_enables = pend_q ? lanes_q : LANES_IDLE;
    assign bus.page_cache_disable = 1'b0;
    assign bus.page_write_through = 1'b0;
    assign bus.cache_n = 1'b0;
    assign bus.split_cycle_flag = 1'b0;
    assign bus.burst_ack_n = !(pend_q && com_q == 1'b0);
    assign bus.cycle_commit_out = com_q;
    assign bus.cycle_commit_oe_n = oe_n_q;
    assign bus.bus_floated = float_q;
    assign req_ready = rdy_q;
    assign reissued = re_q;
endmodule

// ==== verification/cyc_ctrl_sva.sv ====
// assertions on the cycle-control link between both ends
`timescale 1ns/10ps
module cyc_ctrl_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [cyc_ctrl_pkg::ADDR_W-1:0] addr,
    input wire logic addr_strobe_n,
    input wire logic local_int_ctrl_range_hit_n,
    input wire logic attr_latch_strobe_n,
    input wire logic sram_lane_latch_strobe_n,
    input wire logic burst_ack_n,
    input wire logic cache_burst_ack_n,
    input wire logic burst_final_n,
    input wire logic bus_backoff_n,
    input wire logic bus_floated
);
    import cyc_ctrl_pkg::*;
    logic in_win;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // window is inclusive at both bounds
    assign in_win = (addr >= LIC_LO) && (addr <= LIC_HI);
    a_decode_window: assert property (!addr_strobe_n |=>
        local_int_ctrl_range_hit_n == !$past(in_win)) else $error("decode flag wrong");
    a_attr_follows: assert property (!addr_strobe_n |=> !attr_latch_strobe_n)
        else $error("attribute strobe missing");
    a_attr_single: assert property (!attr_latch_strobe_n |->
        !$past(addr_strobe_n) ##1 attr_latch_strobe_n) else $error("attribute strobe without cause");
    a_sram_open_once: assert property (!addr_strobe_n |=>
        !sram_lane_latch_strobe_n ##1 sram_lane_latch_strobe_n) else $error("sram strobe wrong");
    a_final_with_ack: assert property ((!burst_final_n && (!burst_ack_n || !cache_burst_ack_n)) |=>
        burst_final_n) else $error("burst final outlives last ready");
    a_float_next: assert property ($fell(bus_backoff_n) |=> bus_floated)
        else $error("bus not floated after back-off");
    a_float_held: assert property (!bus_backoff_n && !$past(bus_backoff_n) |-> bus_floated)
        else $error("bus driven during back-off");
    a_hold_quiet: assert property (!bus_backoff_n && !$past(bus_backoff_n) |-> addr_strobe_n)
        else $error("cycle started during back-off");
    // main scenarios reached
    c_strobe: cover property (!addr_strobe_n);
    c_final: cover property (!burst_final_n);
    c_backoff: cover property ($fell(bus_backoff_n));
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench joining both ends of the cycle-control link
`timescale 1ns/10ps
module tb_top;
    import cyc_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cfg_phase, cfg_value, burst_req, snoop_hit, deadlock, req_valid, commit_req, cache_ack_n;
    logic [ADDR_W-1:0] req_addr;
    logic [LANES-1:0] req_lanes, lanes_latched;
    logic drive_strength_cfg, owned, aborted, req_ready, reissued;
    logic [31:0] seed = 32'h8D8F;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    cyc_ctrl_if link();
    assign link.cache_burst_ack_n = cache_ack_n;
    // the package deadlock limit is passed through unchanged
    // the default limit leaves room for a full burst and commit before a stall back-off
    cache_cycle_ctrl #(.DEADLOCK_LIMIT_P(DEADLOCK_LIMIT)) i_cache_cycle_ctrl (.mclk(mclk), .rst(rst), .ce(1'b1),
        .bus(link.ctrl), .cfg_phase(cfg_phase), .burst_req(burst_req), .snoop_hit(snoop_hit), .deadlock(deadlock),
        .drive_strength_cfg(drive_strength_cfg), .cycle_owned_by_mbc(owned), .cycle_aborted(aborted),
        .lanes_latched(lanes_latched));
    cyc_far_end i_cyc_far_end (.mclk(mclk), .rst(rst), .ce(1'b1), .bus(link.far), .req_valid(req_valid),
        .req_addr(req_addr), .req_lanes(req_lanes), .cfg_phase(cfg_phase), .cfg_value(cfg_value),
        .commit_req(commit_req), .req_ready(req_ready), .reissued(reissued));
    cyc_ctrl_sva i_cyc_ctrl_sva (.mclk(mclk), .rst(rst), .addr(link.addr), .addr_strobe_n(link.addr_strobe_n),
        .local_int_ctrl_range_hit_n(link.local_int_ctrl_range_hit_n), .attr_latch_strobe_n(link.attr_latch_strobe_n),
        .sram_lane_latch_strobe_n(link.sram_lane_latch_strobe_n), .burst_ack_n(link.burst_ack_n),
        .cache_burst_ack_n(link.cache_burst_ack_n), .burst_final_n(link.burst_final_n),
        .bus_backoff_n(link.bus_backoff_n), .bus_floated(link.bus_floated));
    always #2.5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic exp_hit_n(input logic [ADDR_W-1:0] a);
        return !((a >= LIC_LO) && (a <= LIC_HI));
    endfunction
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // counts abort pulses and ownership cycles over a span
    task automatic watch(input int n, output int ab, output int own);
        ab = 0;
        own = 0;
        repeat (n) begin
            @(posedge mclk);
            if (aborted === 1'b1) ab++;
            if (owned === 1'b1) own++;
        end
    endtask
    // one cycle: issue, decode and lanes, acks, then snoop abort or commit
    task automatic run_cycle(input logic [35:0] a, input logic [7:0] ln, input int beats, input logic snoop);
        int i, nfin, at, ab, own;
        i = 0;
        do begin @(posedge mclk); i++; end while (req_ready !== 1'b1 && i < 60);
        req_valid <= 1'b1;
        req_addr <= a;
        req_lanes <= ln;
        burst_req <= (beats == 4);
        i = 0;
        do begin @(posedge mclk); i++; end while (link.addr_strobe_n !== 1'b0 && i < 20);
        req_valid <= 1'b0;
        #1 check("decode", link.local_int_ctrl_range_hit_n, exp_hit_n(a));
        @(posedge mclk);
        #1 check("lanes", lanes_latched, ln);
        nfin = 0;
        at = 0;
        @(posedge mclk);
        cache_ack_n <= 1'b0;
        for (i = 1; i <= beats; i++) begin
            @(posedge mclk);
            if (link.burst_final_n === 1'b0) begin
                nfin++;
                at = i;
            end
            if (i == beats) cache_ack_n <= 1'b1;
        end
        check("burst_final", nfin * 16 + at, 16 + beats);
        if (snoop) begin
            snoop_hit <= 1'b1;
            watch(8, ab, own);
            snoop_hit <= 1'b0;
            check("abort", ab != 0, 1);
            // the bus controller retires the processor's cycle; the idle controller ignores it
            commit_req <= 1'b1;
            watch(8, ab, own);
            commit_req <= 1'b0;
            check("owned_after_abort", own, 0);
        end else begin
            commit_req <= 1'b1;
            watch(8, ab, own);
            commit_req <= 1'b0;
            check("owned", own != 0, 1);
            snoop_hit <= 1'b1;
            watch(6, ab, own);
            snoop_hit <= 1'b0;
            check("late_abort", ab, 0);
        end
    endtask
    // cuts a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        int k, ab, own;
        {cfg_phase, cfg_value, burst_req, snoop_hit, deadlock, req_valid, commit_req} = '0;
        cache_ack_n = 1'b1;
        req_addr = '0;
        req_lanes = LANES_IDLE;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 check("decode_idle", link.local_int_ctrl_range_hit_n, 1);
        check("lanes_idle", lanes_latched, LANES_IDLE);
        // pin read as configuration, both levels
        @(posedge mclk);
        cfg_phase <= 1'b1;
        for (k = 0; k < 2; k++) begin
            cfg_value <= k[0];
            repeat (6) @(posedge mclk);
            check("drive_cfg", drive_strength_cfg, k[0]);
        end
        cfg_phase <= 1'b0;
        $display("test config done");
        // window corners and their neighbours, then random offsets from the window base up to 0FEE00FFF
        run_cycle(LIC_LO, 8'h00, 1, 1'b0);
        run_cycle(LIC_HI, 8'hFE, 4, 1'b0);
        run_cycle(LIC_LO - 1, 8'h7F, 1, 1'b1);
        run_cycle(LIC_HI + 1, 8'hA5, 4, 1'b1);
        for (k = 0; k < 12; k++) begin
            seed = xs(seed);
            run_cycle({4'h0, 20'hFEE00, seed[11:0]}, seed[19:12], seed[20] ? 4 : 1, seed[21]);
        end
        $display("test cycles done");
        // back-off with a cycle in flight, then reissue
        req_valid <= 1'b1;
        req_addr <= LIC_HI;
        req_lanes <= 8'h0F;
        repeat (3) @(posedge mclk);
        req_valid <= 1'b0;
        deadlock <= 1'b1;
        for (k = 0; k < 20 && link.bus_backoff_n !== 1'b0; k++) @(posedge mclk);
        check("backoff", link.bus_backoff_n, 0);
        @(posedge mclk);
        check("refused", req_ready, 0);
        deadlock <= 1'b0;
        ab = 0;
        // commit soon after the reissue, before the stall counter can back off again
        for (k = 0; k < 12 && ab == 0; k++) begin
            @(posedge mclk);
            if (reissued === 1'b1) ab++;
        end
        check("reissue", {ab != 0, link.bus_backoff_n}, 2'h3);
        commit_req <= 1'b1;
        watch(8, ab, own);
        commit_req <= 1'b0;
        check("owned_after_reissue", own != 0, 1);
        $display("test backoff done");
        wrap_up();
    end
endmodule
